// *** dv/lem_link_partner.sv ***
// Far-side model: lane decoders behind a link transmitter, giving error pulses and lock levels.
// Assumes the bench calls its tasks; every output changes on the falling clock edge.
module lem_link_partner (
  // Clock.
  input  wire logic       i_core_clk,
  // Lane events and levels.
  output logic      [7:0] o_disparity_fault,
  output logic      [7:0] o_invalid_code_fault,
  output logic      [7:0] o_stray_control_char_fault,
  output logic      [7:0] o_code_group_locked,
  output logic      [7:0] o_frame_aligned,
  output logic      [7:0] o_checksum_ok
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0][7:0] ev = '0;
  logic [2:0][7:0] lvl = '1;
  logic [3:0]      down = 4'h0;
  int              req_kind = 0;
  int              req_lane = 0;
  int              req_cnt = 0;
  int              done_cnt = 0;
  assign o_disparity_fault          = ev[0];
  assign o_invalid_code_fault       = ev[1];
  assign o_stray_control_char_fault = ev[2];
  assign o_code_group_locked        = lvl[0];
  assign o_frame_aligned            = lvl[1];
  assign o_checksum_ok              = lvl[2];
  // A lost level comes back after eight cycles, as a transmitter resending would give.
  // A drop asked for at a rising edge is applied at the next falling edge, so no race.
  always @(negedge i_core_clk) begin
    if (req_cnt != done_cnt) begin
      lvl[req_kind][req_lane] = 1'b0;
      down = 4'h1;
      done_cnt = req_cnt;
    end else if (down == 4'h8) begin
      lvl = '1;
      down = 4'h0;
    end else if (down != 4'h0) begin
      down = down + 4'h1;
    end
  end
  task automatic pulse(input int kind, input int lane);
    @(negedge i_core_clk);
    ev[kind][lane] = 1'b1;
    @(negedge i_core_clk);
    ev = '0;
  endtask
  task automatic lose(input int kind, input int lane);
    @(posedge i_core_clk);
    req_kind = kind;
    req_lane = lane;
    req_cnt++;
  endtask
endmodule

// *** dv/tb.sv ***
// Self-checking bench for the lane error monitor, random lanes and limits from a fixed seed.
// Assumes the partner model drives the lane side; registers are reached by strobe port.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lem_pkg::*;
  logic       clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [10:0] reg_addr = 11'h000;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] rdata, skew, disp, inv, stray, cgs, frm, chk;
  logic       rvalid, sync_n, irq_n;
  int         fails = 0;
  int         num_checks = 0;
  logic [7:0] d, lim;
  int         ln;
  initial begin
    forever #10 clk = ~clk;
  end
  lem_lane_error_monitor lem_lane_error_monitor_i (
    .i_core_clk(clk), .i_arst_n(arst_n), .i_reg_wr(reg_wr), .i_reg_rd(reg_rd),
    .i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .i_disparity_fault(disp), .i_invalid_code_fault(inv),
    .i_stray_control_char_fault(stray), .i_code_group_locked(cgs),
    .i_frame_aligned(frm), .i_checksum_ok(chk), .o_lane_skew_align(skew),
    .o_sync_req_n(sync_n), .o_irq_n(irq_n));
  lem_link_partner lem_link_partner_i (
    .i_core_clk(clk), .o_disparity_fault(disp), .o_invalid_code_fault(inv),
    .o_stray_control_char_fault(stray), .o_code_group_locked(cgs),
    .o_frame_aligned(frm), .o_checksum_ok(chk));
  function automatic logic [7:0] sel(input int lane, input int t);
    return {1'b0, lane[2:0], 2'b00, t[1:0]};
  endfunction
  function automatic logic [7:0] bitof(input int n);
    return 8'h01 << n;
  endfunction
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic wr(input logic [10:0] a, input logic [7:0] v);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = v;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask
  task automatic rc(input logic [10:0] a, input logic [7:0] exp);
    int n;
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    n = 0;
    while (rvalid !== 1'b1 && n < 4) begin
      @(negedge clk);
      n++;
    end
    chk8({7'h00, rvalid}, 8'h01);
    chk8(rdata, exp);
  endtask
  task automatic stop_test();
    $display("Checks %0d, mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    #(20 * 20000);
    fails++;
    stop_test();
  end
  initial begin
    void'($urandom(83185));
    repeat (3) @(negedge clk);
    arst_n = 1'b1;
    chk8(skew, RST_DESKEW);
    rc(ADR_DESKEW, 8'h0F);
    d = 8'($urandom);
    wr(ADR_DESKEW, d);
    chk8(skew, d);
    rc(11'h400, 8'h00);
    $display("Test deskew done");
    rc(ADR_ERR_LIMIT, RST_ERR_LIMIT);
    lem_link_partner_i.pulse(0, 3);
    wr(ADR_DISP, 8'h43);
    lem_link_partner_i.pulse(0, 3);
    wr(ADR_CNT_MON, sel(3, 0));
    rc(ADR_CNT_MON, 8'h01);
    wr(ADR_DISP, 8'h82);
    wr(ADR_DISP, 8'h23);
    rc(ADR_CNT_MON, 8'h00);
    wr(ADR_ERR_LIMIT, 8'h01);
    lem_link_partner_i.pulse(0, 0);
    lem_link_partner_i.pulse(1, 1);
    lem_link_partner_i.pulse(1, 5);
    lem_link_partner_i.pulse(2, 7);
    rc(ADR_DISP, 8'h01);
    rc(ADR_INVALID, 8'h22);
    rc(ADR_STRAY, 8'h80);
    wr(ADR_STRAY, 8'h87);
    rc(ADR_STRAY, 8'h00);
    wr(ADR_DISP, 8'h20);
    wr(ADR_INVALID, 8'h21);
    wr(ADR_INVALID, 8'h25);
    wr(ADR_STRAY, 8'h27);
    rc(ADR_INVALID, 8'h00);
    wr(ADR_CNT_MON, 8'h03);
    rc(ADR_CNT_MON, 8'h00);
    $display("Test corner cases done");
    for (int t = 0; t < 3; t++) begin
      ln = $urandom % 8;
      lim = 8'(2 + $urandom % 4);
      wr(ADR_ERR_LIMIT, lim);
      wr(ADR_IRQ_VECTOR, 8'h80 >> t);
      repeat (lim - 1) lem_link_partner_i.pulse(t, ln);
      rc(ADR_DISP + 11'(t), 8'h00);
      lem_link_partner_i.pulse(t, ln);
      rc(ADR_DISP + 11'(t), bitof(ln));
      wr(ADR_CNT_MON, sel(ln, t));
      rc(ADR_CNT_MON, lim);
      chk8({7'h00, irq_n}, 8'h00);
      wr(ADR_DISP + 11'(t), 8'h80 | 8'(ln));
      rc(ADR_DISP + 11'(t), 8'h00);
      chk8({7'h00, irq_n}, 8'h01);
      wr(ADR_DISP + 11'(t), 8'h40 | 8'(ln));
      repeat (2) lem_link_partner_i.pulse(t, ln);
      rc(ADR_CNT_MON, lim);
      wr(ADR_DISP + 11'(t), 8'h20 | 8'(ln));
      lem_link_partner_i.pulse(t, ln ^ 1);
      rc(ADR_CNT_MON, 8'h00);
      wr(ADR_CNT_MON, sel(ln ^ 1, t));
      rc(ADR_CNT_MON, 8'h01);
      $display("Test error type %0d done", t);
    end
    for (int k = 0; k < 3; k++) begin
      ln = $urandom % 8;
      wr(ADR_IRQ_VECTOR, bitof(k));
      lem_link_partner_i.lose(k, ln);
      repeat (2) @(negedge clk);
      chk8({7'h00, sync_n}, (k == 2) ? 8'h01 : 8'h00);
      rc(ADR_CGS_FLAGS + 11'(k), ~bitof(ln));
      repeat (10) @(negedge clk);
      rc(ADR_IRQ_VECTOR, bitof(k));
      chk8({6'h00, irq_n, sync_n}, 8'h01);
      wr(ADR_CGS_FLAGS + 11'(k), 8'h80);
      rc(ADR_IRQ_VECTOR, 8'h00);
      $display("Test level %0d done", k);
    end
    stop_test();
  end
endmodule

// *** inc/lem_pkg.sv ***
// Package for the lane error monitor: register map, field positions, reset values, state.
// Assumes eight link lanes and an 8-bit register port with 11-bit addresses.
package lem_pkg;
  localparam int           LANES          = 8;
  localparam int           ERR_TYPES      = 3;
  localparam logic [10:0]  ADR_CNT_MON    = 11'h46B;
  localparam logic [10:0]  ADR_DESKEW     = 11'h46C;
  localparam logic [10:0]  ADR_DISP       = 11'h46D;
  localparam logic [10:0]  ADR_INVALID    = 11'h46E;
  localparam logic [10:0]  ADR_STRAY      = 11'h46F;
  localparam logic [10:0]  ADR_CGS_FLAGS  = 11'h470;
  localparam logic [10:0]  ADR_FRM_FLAGS  = 11'h471;
  localparam logic [10:0]  ADR_CHK_FLAGS  = 11'h472;
  localparam logic [10:0]  ADR_IRQ_VECTOR = 11'h47A;
  localparam logic [10:0]  ADR_ERR_LIMIT  = 11'h47C;
  localparam int           BIT_IRQ_CLR    = 7;
  localparam int           BIT_CNT_OFF    = 6;
  localparam int           BIT_CNT_CLR    = 5;
  localparam int           LANE_PICK_LSB  = 0;
  localparam int           SEL_LANE_LSB   = 4;
  localparam int           SEL_TYPE_LSB   = 0;
  localparam int           VEC_CGS        = 0;
  localparam int           VEC_FRAME      = 1;
  localparam int           VEC_CHKSUM     = 2;
  localparam int           VEC_ERR_TOP    = 7;
  localparam logic [7:0]   RST_DESKEW     = 8'h0F;
  localparam logic [7:0]   RST_ERR_LIMIT  = 8'hFF;
  localparam logic [7:0]   RST_MASK       = 8'h00;
  localparam logic [7:0]   CNT_MAX        = 8'hFF;
  localparam logic [1:0]   TYPE_DISP      = 2'h0;
  localparam logic [1:0]   TYPE_INVALID   = 2'h1;
  localparam logic [1:0]   TYPE_STRAY     = 2'h2;

  typedef struct packed {
    logic [7:0]            deskew;
    logic [7:0]            limit;
    logic [7:0]            mask;
    logic [2:0][7:0]       stat;
    logic [2:0][7:0]       off;
    logic [2:0][7:0][7:0]  cnt;
    logic [2:0][7:0]       lock_q;
    logic [2:0]            vflag;
    logic [2:0]            sel_lane;
    logic [1:0]            sel_type;
    logic [7:0]            rdata;
    logic                  rvalid;
    logic                  irq_n;
    logic                  sync_n;
  } lem_state_t;
endpackage

// *** rtl/lem_lane_error_monitor.sv ***
// Per-lane error counters, threshold status, sync flags and interrupt for a serial link receiver.
// Assumes lane decoders on the same clock deliver one-cycle error pulses and lock levels.
// Contract
// - Per-lane deskew bits, reset to 0xF.
// - Disparity status bit set at threshold.
// - Bit 7 write clears addressed disparity interrupt.
// - Bit 6 write disables addressed disparity counter.
// - Bit 5 write zeroes addressed disparity counter.
// - Bits 2..0 address the lane acted on.
// - Invalid-code status bit set at threshold.
// - Stray-control status bit set at threshold.
// - Bit 7 clears invalid/stray lane interrupt.
// - Bit 6 stops invalid/stray lane counter.
// - Bit 5 clears invalid/stray lane counter.
// - Select 01 invalid-code, 10 stray-control counter.
// - Per-lane code-group lock; vector bit 0.
// - Any lane unlocked asserts sync request.
// - Bit 7 write clears sync/checksum interrupts.
// - Frame flags show live lane alignment.
// - Frame loss restarts synchronization automatically.
// - Per-lane checksum flag; vector bit 2.
// - Select 00 picks disparity counter.
// - Write selects, then read returns count.
// - Masked threshold event drives interrupt low.
module lem_lane_error_monitor (
  // Clock and reset.
  input  wire logic        i_core_clk,
  input  wire logic        i_arst_n,
  // Register port.
  input  wire logic        i_reg_wr,
  input  wire logic        i_reg_rd,
  input  wire logic [10:0] i_reg_addr,
  input  wire logic [7:0]  i_reg_wdata,
  output logic      [7:0]  o_reg_rdata,
  output logic             o_reg_rvalid,
  // Lane decoder events and levels.
  input  wire logic [7:0]  i_disparity_fault,
  input  wire logic [7:0]  i_invalid_code_fault,
  input  wire logic [7:0]  i_stray_control_char_fault,
  input  wire logic [7:0]  i_code_group_locked,
  input  wire logic [7:0]  i_frame_aligned,
  input  wire logic [7:0]  i_checksum_ok,
  // Link control and interrupt.
  output logic      [7:0]  o_lane_skew_align,
  output logic             o_sync_req_n,
  output logic             o_irq_n
);
  import lem_pkg::*;

  lem_state_t s_r;
  lem_state_t s_nxt;
  logic [2:0][7:0] fault;
  logic [2:0][7:0] live;
  logic [2:0][7:0] hit;
  logic [7:0]      vec;

  assign fault = {i_stray_control_char_fault, i_invalid_code_fault, i_disparity_fault};
  assign live  = {i_checksum_ok, i_frame_aligned, i_code_group_locked};

  always_comb begin
    vec = 8'h00;
    for (int t = 0; t < ERR_TYPES; t++) begin
      vec[VEC_ERR_TOP - t] = |s_r.stat[t];
    end
    vec[VEC_CGS]    = s_r.vflag[VEC_CGS];
    vec[VEC_FRAME]  = s_r.vflag[VEC_FRAME];
    vec[VEC_CHKSUM] = s_r.vflag[VEC_CHKSUM];
  end

  always_comb begin
    s_nxt        = s_r;
    s_nxt.rvalid = 1'b0;
    hit          = '0;
    // Error counters and threshold status per type and lane.
    for (int t = 0; t < ERR_TYPES; t++) begin
      for (int l = 0; l < LANES; l++) begin
        hit[t][l] = fault[t][l] && !s_r.off[t][l] && (s_r.cnt[t][l] != CNT_MAX);
        if (hit[t][l]) begin
          s_nxt.cnt[t][l] = s_r.cnt[t][l] + 8'h01;
        end
        if (i_reg_wr && (i_reg_addr == ADR_DISP + 11'(t)) &&
            (i_reg_wdata[LANE_PICK_LSB +: 3] == 3'(l))) begin
          if (i_reg_wdata[BIT_IRQ_CLR]) begin
            s_nxt.stat[t][l] = 1'b0;
          end
          if (i_reg_wdata[BIT_CNT_OFF]) begin
            s_nxt.off[t][l] = 1'b1;
          end
          if (i_reg_wdata[BIT_CNT_CLR]) begin
            s_nxt.cnt[t][l]  = 8'h00;
            s_nxt.off[t][l]  = 1'b0;
            s_nxt.stat[t][l] = 1'b0;
          end
        end
        // A threshold event in the clearing cycle still sets the status bit.
        if (hit[t][l] && (s_r.cnt[t][l] + 8'h01 == s_r.limit)) begin
          s_nxt.stat[t][l] = 1'b1;
        end
      end
    end
    // Sticky loss flags for the interrupt vector.
    for (int k = 0; k < 3; k++) begin
      if (i_reg_wr && (i_reg_addr == ADR_CGS_FLAGS + 11'(k)) && i_reg_wdata[BIT_IRQ_CLR]) begin
        s_nxt.vflag[k] = 1'b0;
      end
      if (|(s_r.lock_q[k] & ~live[k])) begin
        s_nxt.vflag[k] = 1'b1;
      end
    end
    s_nxt.lock_q = live;
    // Register writes.
    if (i_reg_wr) begin
      unique case (i_reg_addr)
        ADR_DESKEW:     s_nxt.deskew = i_reg_wdata;
        ADR_ERR_LIMIT:  s_nxt.limit  = i_reg_wdata;
        ADR_IRQ_VECTOR: s_nxt.mask   = i_reg_wdata;
        ADR_CNT_MON: begin
          s_nxt.sel_lane = i_reg_wdata[SEL_LANE_LSB +: 3];
          s_nxt.sel_type = i_reg_wdata[SEL_TYPE_LSB +: 2];
        end
        default: ;
      endcase
    end
    // Register reads answer one cycle later.
    if (i_reg_rd) begin
      s_nxt.rvalid = 1'b1;
      unique case (i_reg_addr)
        ADR_CNT_MON: begin
          if (s_r.sel_type == TYPE_DISP || s_r.sel_type == TYPE_INVALID ||
              s_r.sel_type == TYPE_STRAY) begin
            s_nxt.rdata = s_r.cnt[s_r.sel_type][s_r.sel_lane];
          end else begin
            s_nxt.rdata = 8'h00;
          end
        end
        ADR_DESKEW:     s_nxt.rdata = s_r.deskew;
        ADR_DISP:       s_nxt.rdata = s_r.stat[0];
        ADR_INVALID:    s_nxt.rdata = s_r.stat[1];
        ADR_STRAY:      s_nxt.rdata = s_r.stat[2];
        ADR_CGS_FLAGS:  s_nxt.rdata = i_code_group_locked;
        ADR_FRM_FLAGS:  s_nxt.rdata = i_frame_aligned;
        ADR_CHK_FLAGS:  s_nxt.rdata = i_checksum_ok;
        ADR_IRQ_VECTOR: s_nxt.rdata = vec;
        ADR_ERR_LIMIT:  s_nxt.rdata = s_r.limit;
        default:        s_nxt.rdata = 8'h00;
      endcase
    end
    s_nxt.irq_n  = ~|(vec & s_r.mask);
    // Code-group or frame loss asks the transmitter to resynchronize.
    s_nxt.sync_n = (&i_code_group_locked) && (&i_frame_aligned);
  end

  always_ff @(posedge i_core_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      s_r          <= '0;
      s_r.deskew   <= RST_DESKEW;
      s_r.limit    <= RST_ERR_LIMIT;
      s_r.mask     <= RST_MASK;
      s_r.irq_n    <= 1'b1;
      s_r.sync_n   <= 1'b0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_reg_rdata       = s_r.rdata;
  assign o_reg_rvalid      = s_r.rvalid;
  assign o_lane_skew_align = s_r.deskew;
  assign o_sync_req_n      = s_r.sync_n;
  assign o_irq_n           = s_r.irq_n;

  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_arst_n);

  property p_deskew;
    i_reg_wr && i_reg_addr == ADR_DESKEW |=> o_lane_skew_align == $past(i_reg_wdata);
  endproperty
  a_deskew: assert property (p_deskew) else $error("Deskew write not applied.");

  property p_disp_set;
    hit[0][0] && (s_r.cnt[0][0] + 8'h01 == s_r.limit) |=> s_r.stat[0][0];
  endproperty
  a_disp_set: assert property (p_disp_set) else $error("Disparity status not set.");

  property p_disp_irq_clr;
    i_reg_wr && i_reg_addr == ADR_DISP && i_reg_wdata == 8'h82 && !hit[0][2]
      |=> !s_r.stat[0][2] && $stable(s_r.cnt[0][2]);
  endproperty
  a_disp_irq_clr: assert property (p_disp_irq_clr) else $error("Interrupt clear failed.");

  property p_disp_off;
    i_reg_wr && i_reg_addr == ADR_DISP && i_reg_wdata == 8'h43
      |=> s_r.off[0][3] ##1 (s_r.cnt[0][3] == $past(s_r.cnt[0][3], 1));
  endproperty
  a_disp_off: assert property (p_disp_off) else $error("Counter disable failed.");

  property p_cnt_clr;
    i_reg_wr && i_reg_addr == ADR_INVALID && i_reg_wdata == 8'h25
      |=> s_r.cnt[1][5] == 8'h00 && (!s_r.stat[1][5] || $past(hit[1][5]));
  endproperty
  a_cnt_clr: assert property (p_cnt_clr) else $error("Counter reset failed.");

  property p_stray_set;
    hit[2][7] && (s_r.cnt[2][7] + 8'h01 == s_r.limit) |=> s_r.stat[2][7];
  endproperty
  a_stray_set: assert property (p_stray_set) else $error("Stray status not set.");

  property p_count;
    hit[1][1] && !i_reg_wr |=> s_r.cnt[1][1] == $past(s_r.cnt[1][1]) + 8'h01;
  endproperty
  a_count: assert property (p_count) else $error("Counter did not advance.");

  property p_irq;
    (vec & s_r.mask) != 8'h00 |=> !o_irq_n;
  endproperty
  a_irq: assert property (p_irq) else $error("Interrupt not driven low.");

  property p_sync;
    !(&i_code_group_locked) |=> !o_sync_req_n;
  endproperty
  a_sync: assert property (p_sync) else $error("Sync request missing.");

  property p_mon_read;
    i_reg_rd && i_reg_addr == ADR_CNT_MON && s_r.sel_type == TYPE_DISP
      |=> o_reg_rvalid && o_reg_rdata == $past(s_r.cnt[0][s_r.sel_lane]);
  endproperty
  a_mon_read: assert property (p_mon_read) else $error("Counter readback wrong.");

  property p_disp_zero;
    i_reg_wr && i_reg_addr == ADR_DISP && i_reg_wdata == 8'h23
      |=> s_r.cnt[0][3] == 8'h00 && !s_r.off[0][3];
  endproperty
  a_disp_zero: assert property (p_disp_zero) else $error("Disparity counter reset failed.");

  property p_invalid_set;
    hit[1][1] && (s_r.cnt[1][1] + 8'h01 == s_r.limit) |=> s_r.stat[1][1];
  endproperty
  a_invalid_set: assert property (p_invalid_set) else $error("Invalid status not set.");

  property p_stray_irq_clr;
    i_reg_wr && i_reg_addr == ADR_STRAY && i_reg_wdata == 8'h87 && !hit[2][7]
      |=> !s_r.stat[2][7];
  endproperty
  a_stray_irq_clr: assert property (p_stray_irq_clr) else $error("Stray clear failed.");

  property p_invalid_off;
    i_reg_wr && i_reg_addr == ADR_INVALID && i_reg_wdata[BIT_CNT_OFF] &&
      !i_reg_wdata[BIT_CNT_CLR]
      |=> s_r.off[1] == ($past(s_r.off[1]) | (8'h01 << ($past(i_reg_wdata) & 8'h07)));
  endproperty
  a_invalid_off: assert property (p_invalid_off) else $error("Invalid disable failed.");

  property p_stray_zero;
    i_reg_wr && i_reg_addr == ADR_STRAY && i_reg_wdata == 8'h27
      |=> s_r.cnt[2][7] == 8'h00 && !s_r.off[2][7];
  endproperty
  a_stray_zero: assert property (p_stray_zero) else $error("Stray reset failed.");

  property p_sel_store;
    i_reg_wr && i_reg_addr == ADR_CNT_MON
      |=> {1'b0, s_r.sel_lane, 2'b00, s_r.sel_type} == ($past(i_reg_wdata) & 8'h73);
  endproperty
  a_sel_store: assert property (p_sel_store) else $error("Counter select not stored.");

  property p_stray_read;
    i_reg_rd && i_reg_addr == ADR_CNT_MON && s_r.sel_type == TYPE_STRAY
      |=> o_reg_rdata == $past(s_r.cnt[2][s_r.sel_lane]);
  endproperty
  a_stray_read: assert property (p_stray_read) else $error("Stray readback wrong.");

  property p_sel_none;
    i_reg_rd && i_reg_addr == ADR_CNT_MON && s_r.sel_type == 2'h3
      |=> o_reg_rdata == 8'h00;
  endproperty
  a_sel_none: assert property (p_sel_none) else $error("Unused type not zero.");

  property p_cgs_flag;
    |(s_r.lock_q[VEC_CGS] & ~i_code_group_locked) |=> vec[VEC_CGS];
  endproperty
  a_cgs_flag: assert property (p_cgs_flag) else $error("Code-group flag not set.");

  property p_frm_clr;
    i_reg_wr && i_reg_addr == ADR_FRM_FLAGS && i_reg_wdata[BIT_IRQ_CLR] &&
      !(|(s_r.lock_q[VEC_FRAME] & ~i_frame_aligned))
      |=> !vec[VEC_FRAME];
  endproperty
  a_frm_clr: assert property (p_frm_clr) else $error("Frame flag not cleared.");

  property p_frm_live;
    i_reg_rd && i_reg_addr == ADR_FRM_FLAGS |=> o_reg_rdata == $past(i_frame_aligned);
  endproperty
  a_frm_live: assert property (p_frm_live) else $error("Frame flags not live.");

  property p_frm_sync;
    !(&i_frame_aligned) |=> !o_sync_req_n;
  endproperty
  a_frm_sync: assert property (p_frm_sync) else $error("Frame loss no resync.");

  property p_chk_flag;
    |(s_r.lock_q[VEC_CHKSUM] & ~i_checksum_ok) |=> vec[VEC_CHKSUM];
  endproperty
  a_chk_flag: assert property (p_chk_flag) else $error("Checksum flag not set.");

  property p_hold;
    s_r.stat[0][0] && !(i_reg_wr && i_reg_addr == ADR_DISP) |=> s_r.stat[0][0];
  endproperty
  a_hold: assert property (p_hold) else $error("Status bit dropped.");

  c_disp_set: cover property (hit[0][0] ##1 s_r.stat[0][0]);
  c_irq_low:  cover property (o_irq_n ##1 !o_irq_n);
  c_resync:   cover property (!o_sync_req_n ##[1:20] o_sync_req_n);
  c_loss:     cover property (!vec[VEC_CGS] ##1 vec[VEC_CGS]);
  c_zero:     cover property (s_r.cnt[0][3] != 8'h00 ##1 s_r.cnt[0][3] == 8'h00);
endmodule
